// ==== src/uart_host_bus_port.sv ====
// device end of the parallel host port: register decode, strobes, data bus
// assumes pins arrive synchronous to core_clk_i and the uart engine sits on the user side
// Summary of operation
// - reset high holds device inactive
// - reset clears control, keeps data and divisors
// - reset selects crystal rate on clock output
// - software picks crystal or baud clock output
// - system supplies 11.0592 MHz crystal clock; the 25 MHz core clock stands in for it
// - single-port mode opens modem registers to bus
// - address plus divisor access bit picks register
// - single-port latches four address bits on strobe
// - dual-port decodes only three address bits
// - read drives data only with strobe and select
// - write data taken on write strobe rise
// - write without chip select does nothing
// - one shared eight-bit bidirectional data bus
// - chip select low gates access, latched single-port
`timescale 1ns/10ps
module uart_host_bus_port (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  uart_host_bus_if.device_mp bus,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] line_status_i,
  input wire logic [7:0] modem_status_i,
  input wire logic [7:0] int_ident_i,
  output logic [7:0] tx_data_o,
  output logic tx_load_o,
  output logic rx_ready_o,
  output logic [7:0] int_enable_o,
  output logic [7:0] line_ctrl_o,
  output logic [7:0] modem_ctrl_o,
  output logic [63:0] modem_regs_o,
  output logic baud_tick_o,
  output logic clk_out_o
);
  logic ctrl_clear;
  logic wr_n_prev_reg;
  logic rd_n_prev_reg;
  logic cs_n_prev_reg;
  logic ads_prev_reg;
  logic [3:0] addr_prev_reg;
  logic [7:0] data_prev_reg;
  logic [3:0] addr_lat_reg;
  logic cs_n_lat_reg;
  logic [3:0] eff_addr;
  logic cs_active;
  logic divisor_latch_access;
  logic wr_evt;
  logic rd_qual;
  logic rd_data_evt;
  logic [7:0] rbr_reg;
  logic [7:0] scratch_reg;
  logic [7:0] dll_reg;
  logic [7:0] dlm_reg;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic oe_reg;
  localparam int MODEM_REG_COUNT_L = uart_host_bus_pkg::MODEM_REG_COUNT;
  logic [7:0] modem_mem [MODEM_REG_COUNT_L];

  // chip reset pin acts alongside the core reset on control state; it also blocks strobes and clears rx_ready
  assign ctrl_clear = !nrst_i || bus.chip_reset;
  assign divisor_latch_access = line_ctrl_o[uart_host_bus_pkg::LINE_CTRL_DIVISOR_LATCH_ACCESS_BIT];

  // pin samples, used for edge detection
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wr_n_prev_reg <= 1'b1;
      rd_n_prev_reg <= 1'b1;
      cs_n_prev_reg <= 1'b1;
      ads_prev_reg <= 1'b1;
      addr_prev_reg <= 4'h0;
      data_prev_reg <= 8'h00;
    end else if (ce_i) begin
      wr_n_prev_reg <= bus.write_strobe_n;
      rd_n_prev_reg <= bus.read_strobe_n;
      cs_n_prev_reg <= bus.chip_select_n;
      ads_prev_reg <= bus.addr_latch_strobe;
      addr_prev_reg <= bus.reg_addr;
      data_prev_reg <= bus.host_data_bus;
    end
  end

  // single-port address and select capture on the strobe rising edge
  always_ff @(posedge core_clk_i) begin
    if (ctrl_clear) begin
      addr_lat_reg <= 4'h0;
      cs_n_lat_reg <= 1'b1;
    end else if (ce_i && bus.single_port_select && !ads_prev_reg && bus.addr_latch_strobe) begin
      addr_lat_reg <= bus.reg_addr;
      cs_n_lat_reg <= bus.chip_select_n;
    end
  end

  // address and select seen by the decoder
  always_comb begin
    if (bus.single_port_select) begin
      eff_addr = addr_lat_reg;
      cs_active = !cs_n_lat_reg;
    end else begin
      eff_addr = {1'b0, addr_prev_reg[2:0]};
      cs_active = !cs_n_prev_reg;
    end
  end

  // write only on strobe rise with select, never during chip reset
  assign wr_evt = !wr_n_prev_reg && bus.write_strobe_n && cs_active && !bus.chip_reset;
  assign rd_qual = !rd_n_prev_reg && cs_active && !bus.chip_reset;
  assign rd_data_evt = rd_qual && !oe_reg && (eff_addr == {1'b0, uart_host_bus_pkg::ADDR_DATA}) && !divisor_latch_access;

  // holding and divisor latches survive the chip reset pin
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tx_data_o <= uart_host_bus_pkg::DATA_RESET;
      tx_load_o <= 1'b0;
      dll_reg <= uart_host_bus_pkg::DIVISOR_RESET[7:0];
      dlm_reg <= uart_host_bus_pkg::DIVISOR_RESET[15:8];
    end else if (ce_i) begin
      tx_load_o <= 1'b0;
      if (wr_evt && !eff_addr[3]) begin
        if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_DATA && divisor_latch_access) begin
          dll_reg <= data_prev_reg;
        end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_DATA) begin
          tx_data_o <= data_prev_reg;
          tx_load_o <= 1'b1;
        end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_INT_ENABLE && divisor_latch_access) begin
          dlm_reg <= data_prev_reg;
        end
      end
    end
  end

  // control registers, cleared by either reset
  always_ff @(posedge core_clk_i) begin
    if (ctrl_clear) begin
      int_enable_o <= uart_host_bus_pkg::CTRL_RESET;
      line_ctrl_o <= uart_host_bus_pkg::CTRL_RESET;
      modem_ctrl_o <= uart_host_bus_pkg::CTRL_RESET;
      scratch_reg <= uart_host_bus_pkg::CTRL_RESET;
    end else if (ce_i && wr_evt && !eff_addr[3]) begin
      if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_INT_ENABLE && !divisor_latch_access) begin
        int_enable_o <= data_prev_reg;
      end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_LINE_CTRL) begin
        line_ctrl_o <= data_prev_reg;
      end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_MODEM_CTRL) begin
        modem_ctrl_o <= data_prev_reg;
      end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_SCRATCH) begin
        scratch_reg <= data_prev_reg;
      end
    end
  end

  // modem register bank, reachable only in single-port mode
  genvar gi;
  generate
    for (gi = 0; gi < MODEM_REG_COUNT_L; gi++) begin : g_modem
      always_ff @(posedge core_clk_i) begin
        if (ctrl_clear) begin
          modem_mem[gi] <= uart_host_bus_pkg::CTRL_RESET;
        end else if (ce_i && wr_evt && eff_addr == {1'b1, 3'(gi)}) begin
          modem_mem[gi] <= data_prev_reg;
        end
      end
      assign modem_regs_o[gi*8 +: 8] = modem_mem[gi];
    end
  endgenerate

  // receive buffer; a new byte wins over a read in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rbr_reg <= uart_host_bus_pkg::DATA_RESET;
      rx_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (rx_valid_i) begin
        rbr_reg <= rx_data_i;
        rx_ready_o <= 1'b1;
      end else if (rd_data_evt || bus.chip_reset) begin
        rx_ready_o <= 1'b0;
      end
    end
  end

  // read mux
  always_comb begin
    rdata_next = 8'h00;
    if (eff_addr[3]) begin
      rdata_next = modem_mem[eff_addr[2:0]];
    end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_DATA) begin
      rdata_next = divisor_latch_access ? dll_reg : rbr_reg;
    end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_INT_ENABLE) begin
      rdata_next = divisor_latch_access ? dlm_reg : int_enable_o;
    end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_INT_IDENT) begin
      rdata_next = int_ident_i;
    end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_LINE_CTRL) begin
      rdata_next = line_ctrl_o;
    end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_MODEM_CTRL) begin
      rdata_next = modem_ctrl_o;
    end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_LINE_STATUS) begin
      rdata_next = {line_status_i[7:1], rx_ready_o};
    end else if (eff_addr[2:0] == uart_host_bus_pkg::ADDR_MODEM_STATUS) begin
      rdata_next = modem_status_i;
    end else begin
      rdata_next = scratch_reg;
    end
  end

  // drivers on only while a qualified read stands
  always_ff @(posedge core_clk_i) begin
    if (ctrl_clear) begin
      oe_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (ce_i) begin
      oe_reg <= rd_qual;
      rdata_reg <= rd_qual ? rdata_next : 8'h00;
    end
  end

  assign bus.dev_data_o = rdata_reg;
  assign bus.dev_data_oe = oe_reg;

  uart_clock_out_gen uart_clock_out_gen_inst (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .ctrl_clear_i(ctrl_clear),
    .divisor_i({dlm_reg, dll_reg}),
    .baud_sel_i(modem_ctrl_o[uart_host_bus_pkg::MODEM_CTRL_CLKSEL_BIT]),
    .baud_tick_o(baud_tick_o),
    .clk_out_o(clk_out_o)
  );
endmodule : uart_host_bus_port

// ==== src/uart_host_bus_pkg.sv ====
// shared constants for both ends of the parallel host port
// assumes a single 25 MHz core clock on both ends
package uart_host_bus_pkg;

  // clocking
  localparam int CLK_PERIOD_NS = 40;
  localparam int CRYSTAL_KHZ = 11059;
  localparam int STROBE_NS = 150;
  localparam int TURN_NS = 80;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYCLES = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // device register addresses, low three address lines
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_INT_IDENT = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;
  localparam int MODEM_REG_COUNT = 8;

  // field positions and reset values
  localparam int LINE_CTRL_DIVISOR_LATCH_ACCESS_BIT = 7;
  localparam int MODEM_CTRL_CLKSEL_BIT = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;

  // host-side avalon register offsets and fields
  localparam logic [1:0] AV_CMD = 2'h0;
  localparam logic [1:0] AV_CFG = 2'h1;
  localparam logic [1:0] AV_STATUS = 2'h2;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_READ_BIT = 12;
  localparam int CFG_SINGLE_BIT = 0;
  localparam int CFG_RESET_BIT = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DATA_LSB = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LATCH = 2'b01,
    ST_STROBE = 2'b11,
    ST_TURN = 2'b10
  } bus_state_type;

endpackage : uart_host_bus_pkg

// ==== src/uart_host_bus_if.sv ====
// pin-level carrier between the host bus master and the uart port
// the shared data wire idles high when nobody drives it
`timescale 1ns/10ps
interface uart_host_bus_if;
  logic [3:0] reg_addr;
  logic chip_select_n;
  logic addr_latch_strobe;
  logic read_strobe_n;
  logic write_strobe_n;
  logic single_port_select;
  logic chip_reset;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [7:0] dev_data_o;
  logic dev_data_oe;
  logic [7:0] host_data_bus;

  assign host_data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hff);

  modport device_mp (
    input reg_addr, chip_select_n, addr_latch_strobe, read_strobe_n, write_strobe_n,
    input single_port_select, chip_reset, host_data_bus,
    output dev_data_o, dev_data_oe
  );

  modport host_mp (
    output reg_addr, chip_select_n, addr_latch_strobe, read_strobe_n, write_strobe_n,
    output single_port_select, chip_reset, host_data_o, host_data_oe,
    input host_data_bus
  );
endinterface : uart_host_bus_if

// ==== src/uart_clock_out_gen.sv ====
// divisor counter and selectable clock output pin
// assumes the core clock stands in for the crystal
`timescale 1ns/10ps
module uart_clock_out_gen (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic ctrl_clear_i,
  input wire logic [15:0] divisor_i,
  input wire logic baud_sel_i,
  output logic baud_tick_o,
  output logic clk_out_o
);
  logic [15:0] count_reg;

  // divisor zero stops the generator rather than ticking every cycle
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      count_reg <= 16'h0000;
      baud_tick_o <= 1'b0;
    end else if (ce_i) begin
      baud_tick_o <= 1'b0;
      if (divisor_i == 16'h0000) begin
        count_reg <= 16'h0000;
      end else if (count_reg >= divisor_i - 16'h0001) begin
        count_reg <= 16'h0000;
        baud_tick_o <= 1'b1;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // a flop can only reach half the core rate, so crystal mode toggles every cycle
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i || ctrl_clear_i) begin
      clk_out_o <= 1'b0;
    end else if (ce_i) begin
      if (!baud_sel_i) begin
        clk_out_o <= ~clk_out_o;
      end else if (baud_tick_o) begin
        clk_out_o <= ~clk_out_o;
      end
    end
  end
endmodule : uart_clock_out_gen

// ==== src/uart_host_bus_master.sv ====
// host end: avalon-mm slave that runs one parallel bus cycle per command
// assumes the device end samples pins on the same core clock
`timescale 1ns/10ps
module uart_host_bus_master (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  uart_host_bus_if.host_mp bus
);
  uart_host_bus_pkg::bus_state_type state_reg;
  logic go_reg;
  logic cmd_read_reg;
  logic [3:0] cmd_addr_reg;
  logic [7:0] cmd_data_reg;
  logic [1:0] cfg_reg;
  logic [7:0] rd_cap_reg;
  logic [2:0] cnt_reg;
  logic busy;
  logic accept;
  logic [3:0] addr_o_reg;
  logic cs_n_o_reg;
  logic ads_o_reg;
  logic rd_n_o_reg;
  logic wr_n_o_reg;
  logic data_oe_reg;

  assign busy = go_reg || (state_reg != uart_host_bus_pkg::ST_IDLE);
  // a command while busy is held off with waitrequest
  assign accept = (avs_read_i || avs_write_i) && avs_waitrequest_o
                  && !(avs_write_i && avs_address_i == uart_host_bus_pkg::AV_CMD && busy);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      go_reg <= 1'b0;
      cmd_read_reg <= 1'b0;
      cmd_addr_reg <= 4'h0;
      cmd_data_reg <= 8'h00;
      cfg_reg <= 2'h0;
    end else if (ce_i) begin
      avs_waitrequest_o <= !accept;
      if (state_reg == uart_host_bus_pkg::ST_LATCH) begin
        go_reg <= 1'b0;
      end
      if (accept && avs_write_i && avs_address_i == uart_host_bus_pkg::AV_CMD) begin
        go_reg <= 1'b1;
        cmd_data_reg <= avs_writedata_i[7:0];
        cmd_addr_reg <= avs_writedata_i[uart_host_bus_pkg::CMD_ADDR_LSB +: 4];
        cmd_read_reg <= avs_writedata_i[uart_host_bus_pkg::CMD_READ_BIT];
      end else if (accept && avs_write_i && avs_address_i == uart_host_bus_pkg::AV_CFG) begin
        cfg_reg <= avs_writedata_i[1:0];
      end
      if (accept && avs_read_i) begin
        avs_readdata_o <= 32'h0000_0000;
        if (avs_address_i == uart_host_bus_pkg::AV_CFG) begin
          avs_readdata_o[1:0] <= cfg_reg;
        end else if (avs_address_i == uart_host_bus_pkg::AV_STATUS) begin
          avs_readdata_o[uart_host_bus_pkg::STATUS_BUSY_BIT] <= busy;
          avs_readdata_o[uart_host_bus_pkg::STATUS_DATA_LSB +: 8] <= rd_cap_reg;
        end
      end
    end
  end

  // bus cycle: latch address, hold strobe, then turn the data bus around
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_reg <= uart_host_bus_pkg::ST_IDLE;
      cnt_reg <= 3'h0;
      addr_o_reg <= 4'h0;
      cs_n_o_reg <= 1'b1;
      ads_o_reg <= 1'b1;
      rd_n_o_reg <= 1'b1;
      wr_n_o_reg <= 1'b1;
      data_oe_reg <= 1'b0;
      rd_cap_reg <= 8'h00;
    end else if (ce_i) begin
      case (state_reg)
        uart_host_bus_pkg::ST_IDLE: begin
          if (go_reg) begin
            addr_o_reg <= cmd_addr_reg;
            cs_n_o_reg <= 1'b0;
            ads_o_reg <= 1'b0;
            state_reg <= uart_host_bus_pkg::ST_LATCH;
          end
        end
        uart_host_bus_pkg::ST_LATCH: begin
          ads_o_reg <= 1'b1;
          rd_n_o_reg <= !cmd_read_reg;
          wr_n_o_reg <= cmd_read_reg;
          data_oe_reg <= !cmd_read_reg;
          cnt_reg <= 3'h0;
          state_reg <= uart_host_bus_pkg::ST_STROBE;
        end
        uart_host_bus_pkg::ST_STROBE: begin
          if (cnt_reg == 3'(uart_host_bus_pkg::STROBE_CYCLES - 1)) begin
            rd_n_o_reg <= 1'b1;
            wr_n_o_reg <= 1'b1;
            if (cmd_read_reg) begin
              rd_cap_reg <= bus.host_data_bus;
            end
            cnt_reg <= 3'h0;
            state_reg <= uart_host_bus_pkg::ST_TURN;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
        default: begin
          if (cnt_reg == 3'(uart_host_bus_pkg::TURN_CYCLES - 1)) begin
            cs_n_o_reg <= 1'b1;
            data_oe_reg <= 1'b0;
            state_reg <= uart_host_bus_pkg::ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 3'h1;
          end
        end
      endcase
    end
  end

  assign bus.reg_addr = addr_o_reg;
  assign bus.chip_select_n = cs_n_o_reg;
  assign bus.addr_latch_strobe = ads_o_reg;
  assign bus.read_strobe_n = rd_n_o_reg;
  assign bus.write_strobe_n = wr_n_o_reg;
  assign bus.host_data_o = cmd_data_reg;
  assign bus.host_data_oe = data_oe_reg;
  assign bus.single_port_select = cfg_reg[uart_host_bus_pkg::CFG_SINGLE_BIT];
  assign bus.chip_reset = cfg_reg[uart_host_bus_pkg::CFG_RESET_BIT];
endmodule : uart_host_bus_master

// ==== tb/uart_host_bus_properties.sv ====
// concurrent checks on the pins joining host end and device end
// assumes one core clock and the sync active-low nrst_i of both ends
`timescale 1ns/10ps
module uart_host_bus_properties (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic chip_select_n,
  input wire logic addr_latch_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic single_port_select,
  input wire logic chip_reset,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data_o,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_NO_BUS_FIGHT: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  AST_READ_QUALIFIED: assert property ($rose(dev_data_oe) |-> !$past(read_strobe_n) && !chip_select_n)
    else $error("device drove data without read strobe and select");
  AST_READ_ANSWER: assert property ($fell(read_strobe_n) && !chip_select_n && !chip_reset |-> ##[1:3] dev_data_oe)
    else $error("selected read got no data");
  AST_DRIVE_RELEASE: assert property ($rose(read_strobe_n) |-> ##[1:3] !dev_data_oe)
    else $error("device kept driving after read");
  AST_IDLE_HIGHZ: assert property (read_strobe_n [*4] |-> !dev_data_oe)
    else $error("device drives bus with no read");
  AST_RESET_SILENT: assert property (chip_reset && $past(chip_reset) |-> !dev_data_oe)
    else $error("device active during reset");
  AST_READ_STEADY: assert property (dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data_o))
    else $error("read data moved while driven");
  AST_STROBE_SELECTED: assert property (!read_strobe_n || !write_strobe_n |-> !chip_select_n)
    else $error("strobe without chip select");
  AST_ONE_STROBE: assert property (read_strobe_n || write_strobe_n)
    else $error("read and write strobes together");
  AST_WRITE_PULSE: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
    else $error("write strobe width wrong");
  AST_DATA_HELD: assert property ($rose(write_strobe_n) |-> $past(host_data_oe) && host_data_oe)
    else $error("write data not held over strobe rise");
  AST_ADDR_LATCHED: assert property (single_port_select && $fell(write_strobe_n) |-> $rose(addr_latch_strobe))
    else $error("address not latched before strobe");

  cover property ($rose(dev_data_oe));
  cover property ($rose(write_strobe_n));
  cover property (chip_reset);
  cover property (single_port_select && $rose(addr_latch_strobe));
endmodule : uart_host_bus_properties

// ==== tb/tb_top.sv ====
// bench: avalon tasks drive the host end, which runs bus cycles on the device end
// assumes one 25 MHz clock; device user side driven and watched here
`timescale 1ns/10ps
module tb_top;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] rx_data = 8'h00;
  logic rx_valid = 1'b0;
  logic ce = 1'b1;
  logic [7:0] tx_data, int_enable, line_ctrl, modem_ctrl;
  logic [63:0] modem_regs;
  logic tx_load, rx_ready, baud_tick, clk_out;
  logic [7:0] q;
  logic [31:0] r;
  int t;
  int failures = 0;
  int samples_checked = 0;
  int tx_loads = 0;

  // the core clock stands in for the crystal on both ends
  always #20 core_clk_i = ~core_clk_i;

  // tx_load is a one-cycle pulse, so it is counted here rather than polled
  always @(posedge core_clk_i) begin
    if (tx_load === 1'b1) begin
      tx_loads++;
    end
  end

  uart_host_bus_if bus_if();
  uart_host_bus_port uart_host_bus_port_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .bus(bus_if), .rx_data_i(rx_data), .rx_valid_i(rx_valid), .line_status_i(8'h60),
    .modem_status_i(8'h9b), .int_ident_i(8'hc1), .tx_data_o(tx_data), .tx_load_o(tx_load),
    .rx_ready_o(rx_ready), .int_enable_o(int_enable), .line_ctrl_o(line_ctrl), .modem_ctrl_o(modem_ctrl),
    .modem_regs_o(modem_regs), .baud_tick_o(baud_tick), .clk_out_o(clk_out));
  uart_host_bus_master uart_host_bus_master_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .bus(bus_if));
  uart_host_bus_properties uart_host_bus_properties_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .chip_select_n(bus_if.chip_select_n), .addr_latch_strobe(bus_if.addr_latch_strobe),
    .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
    .single_port_select(bus_if.single_port_select), .chip_reset(bus_if.chip_reset),
    .host_data_oe(bus_if.host_data_oe), .dev_data_o(bus_if.dev_data_o), .dev_data_oe(bus_if.dev_data_oe));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low
  task automatic av(input logic rd, input logic [1:0] a, input logic [31:0] wd, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge core_clk_i);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) begin
      chk("waitrequest timeout", 0, 1);
      end_of_test();
    end
  endtask : av

  // one parallel bus cycle, then poll busy until the host end is idle again
  task automatic dev(input logic rd, input logic [3:0] a, input logic [7:0] d, output logic [7:0] dq);
    logic [31:0] s;
    int n;
    av(1'b0, uart_host_bus_pkg::AV_CMD, {19'h0, rd, a, d}, s);
    n = 0;
    do begin
      av(1'b1, uart_host_bus_pkg::AV_STATUS, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 40);
    dq = s[15:8];
    if (n >= 40) begin
      chk("busy timeout", 0, 1);
      end_of_test();
    end
  endtask : dev

  // counts clk_out changes at falling edges, where it has settled
  task automatic toggles(input int cyc, output int cnt);
    logic p;
    cnt = 0;
    @(negedge core_clk_i);
    p = clk_out;
    repeat (cyc) begin
      @(negedge core_clk_i);
      if (clk_out !== p) cnt++;
      p = clk_out;
    end
  endtask : toggles

  task automatic t_reset();
    chk("line_ctrl", 8'h00, line_ctrl);
    chk("modem_ctrl", 8'h00, modem_ctrl);
    toggles(8, t);
    chk("crystal toggles", 8, t);
    av(1'b1, 2'h3, 32'h0, r);
    chk("unmapped read", 32'h0, r);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    dev(1'b0, 4'h7, 8'h5a, q);
    dev(1'b1, 4'h7, 8'h00, q);
    chk("scratch", 8'h5a, q);
    dev(1'b0, 4'h3, 8'h83, q);
    dev(1'b0, 4'h0, 8'h03, q);
    dev(1'b0, 4'h1, 8'h00, q);
    dev(1'b0, 4'h3, 8'h03, q);
    dev(1'b0, 4'h0, 8'hc3, q);
    chk("holding", 8'hc3, tx_data);
    chk("holding loads", 1, tx_loads);
    @(posedge core_clk_i);
    rx_data <= 8'ha5;
    rx_valid <= 1'b1;
    @(posedge core_clk_i);
    rx_valid <= 1'b0;
    dev(1'b1, 4'h5, 8'h00, q);
    chk("line status", 8'h61, q);
    dev(1'b1, 4'h0, 8'h00, q);
    chk("rx buffer", 8'ha5, q);
    chk("rx_ready cleared", 1'b0, rx_ready);
    dev(1'b1, 4'h2, 8'h00, q);
    chk("int ident", 8'hc1, q);
    dev(1'b1, 4'h6, 8'h00, q);
    chk("modem status", 8'h9b, q);
    dev(1'b0, 4'h3, 8'h83, q);
    dev(1'b1, 4'h0, 8'h00, q);
    chk("divisor low", 8'h03, q);
    dev(1'b0, 4'h3, 8'h03, q);
    $display("test regs done");
  endtask : t_regs

  task automatic t_clk();
    dev(1'b0, 4'h4, 8'h20, q);
    toggles(12, t);
    chk("baud toggles", 4, t);
    dev(1'b0, 4'h4, 8'h00, q);
    toggles(12, t);
    chk("crystal toggles", 12, t);
    @(posedge core_clk_i);
    ce <= 1'b0;
    toggles(6, t);
    chk("frozen toggles", 0, t);
    @(posedge core_clk_i);
    ce <= 1'b1;
    $display("test clock out done");
  endtask : t_clk

  task automatic t_modes();
    dev(1'b0, 4'hf, 8'h77, q);
    dev(1'b1, 4'h7, 8'h00, q);
    chk("dual addr3 ignored", 8'h77, q);
    chk("modem regs closed", 64'h0, modem_regs);
    av(1'b0, uart_host_bus_pkg::AV_CFG, 32'h1, r);
    dev(1'b0, 4'ha, 8'h3c, q);
    chk("modem reg 2", 8'h3c, modem_regs[23:16]);
    dev(1'b1, 4'ha, 8'h00, q);
    chk("modem reg 2 read", 8'h3c, q);
    dev(1'b1, 4'h7, 8'h00, q);
    chk("single scratch", 8'h77, q);
    av(1'b0, uart_host_bus_pkg::AV_CFG, 32'h0, r);
    $display("test modes done");
  endtask : t_modes

  task automatic t_chip_reset();
    dev(1'b0, 4'h4, 8'h20, q);
    dev(1'b0, 4'h1, 8'h0f, q);
    av(1'b0, uart_host_bus_pkg::AV_CFG, 32'h2, r);
    dev(1'b0, 4'h1, 8'h05, q);
    chk("ier during reset", 8'h00, int_enable);
    av(1'b0, uart_host_bus_pkg::AV_CFG, 32'h0, r);
    chk("modem_ctrl", 8'h00, modem_ctrl);
    chk("holding kept", 8'hc3, tx_data);
    toggles(12, t);
    chk("crystal after reset", 12, t);
    dev(1'b0, 4'h3, 8'h83, q);
    dev(1'b1, 4'h0, 8'h00, q);
    chk("divisor kept", 8'h03, q);
    $display("test chip reset done");
  endtask : t_chip_reset

  initial begin
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    t_regs();
    t_clk();
    t_modes();
    t_chip_reset();
    end_of_test();
  end
endmodule : tb_top
